// ---- src/edge_sync.sv ----
`timescale 1ns/1ps
`default_nettype none
// Two-flop synchroniser with change detection on the settled value.
module edge_sync #(
    parameter int unsigned WIDTH = 8
) (
    // Clock and reset.
    input wire logic core_clk_in,
    input wire logic rst_in,
    // Raw pins and result.
    input wire logic [WIDTH-1:0] pin_in,
    output logic [WIDTH-1:0] changed_out
);
    logic [WIDTH-1:0] meta; // First stage, read only by the second.
    logic [WIDTH-1:0] sync; // Settled value.
    logic [WIDTH-1:0] prev; // Last settled value.

    // Sample pins; edges are compared only on settled copies.
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            meta <= '0;
            sync <= '0;
            prev <= '0;
            changed_out <= '0;
        end else begin
            meta <= pin_in;
            sync <= meta;
            prev <= sync;
            changed_out <= sync ^ prev;
        end
    end
endmodule
`default_nettype wire

// ---- src/low_power_mode_control.sv ----
`timescale 1ns/1ps
`default_nettype none
module low_power_mode_control #(
    parameter int unsigned WAKE_PINS = lpm_pkg::WAKE_PINS_DEF
) (
    // Clock and reset.
    input wire logic core_clk_in,
    input wire logic rst_in,
    // Recovery timing tick from the watchdog oscillator, already on this clock.
    input wire logic rc_tick_in,
    // Core requests and wake causes.
    input wire lpm_pkg::core_req_t core_req_in,
    input wire lpm_pkg::wake_cause_t cause_in,
    input wire logic watchdog_enabled_in,
    input wire logic irq_enabled_in,
    input wire logic status_clear_in,
    // Wakeup pins and their enables.
    input wire logic [WAKE_PINS-1:0] wake_pin_in,
    input wire logic [WAKE_PINS-1:0] wake_pin_en_in,
    // Power controls and status.
    output lpm_pkg::power_ctl_t power_ctl_out,
    output logic recovery_reset_out,
    output logic wake_flag_out,
    output logic watchdog_irq_out,
    output logic idle_exit_out,
    output lpm_pkg::power_state_t state_out
);
    import lpm_pkg::*;

    power_state_t state; // Current power state.
    power_state_t next_state; // Decoded next state.
    logic [WAKE_CNT_W-1:0] cnt; // Recovery counter.
    logic phase_sys; // High once the oscillator phase is done.
    logic watchdog_run_latched; // Watchdog enable captured at entry.
    logic irq_pending; // Watchdog interrupt owed after recovery.
    logic [WAKE_PINS-1:0] pin_change; // Settled edges on wake pins.

    edge_sync #(.WIDTH(WAKE_PINS)) u_sync (
        .core_clk_in(core_clk_in),
        .rst_in(rst_in),
        .pin_in(wake_pin_in),
        .changed_out(pin_change)
    );

    wire pin_wake = |(pin_change & wake_pin_en_in);
    // Any of the three reset sources counts as one wake cause.
    wire reset_cause = cause_in.power_on_reset | cause_in.low_supply_reset |
                       cause_in.ext_reset;
    // Deep sleep ignores interrupts: with the clock gated there is no core to take them.
    wire sleep_wake = pin_wake | cause_in.watchdog_timeout | reset_cause;
    // Idle wakes on a taken interrupt instead of a pin edge, since the clocks are still running.
    wire idle_wake = core_req_in.irq_taken | cause_in.watchdog_timeout | reset_cause;
    wire osc_done = !phase_sys && rc_tick_in &&
                    cnt == WAKE_CNT_W'(WAKE_OSC_CYCLES - 1);
    wire sys_done = phase_sys && cnt == WAKE_CNT_W'(WAKE_SYS_CYCLES - 1);

    // Next-state decode; the core only reaches low power by its own opcode.
    always_comb begin
        next_state = state;
        case (state)
            ST_RUN: begin
                if (core_req_in.sleep_op) begin
                    next_state = ST_SLEEP;
                end else if (core_req_in.idle_op) begin
                    next_state = ST_IDLE;
                end
            end
            ST_IDLE: begin
                // Clocks never stopped, so no restart delay is needed.
                if (idle_wake) begin
                    next_state = ST_RUN;
                end
            end
            ST_SLEEP: begin
                // Every way out, resets included, goes through recovery.
                if (sleep_wake) begin
                    next_state = ST_RECOVER;
                end
            end
            ST_RECOVER: begin
                if (sys_done) begin
                    next_state = ST_RUN;
                end
            end
            default: begin
                next_state = ST_RUN;
            end
        endcase
    end

    // State, recovery counter and watchdog enable capture.
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            state <= ST_RUN;
            cnt <= WAKE_CNT_RESET;
            phase_sys <= 1'b0;
            watchdog_run_latched <= 1'b0;
        end else begin
            state <= next_state;
            if (state != ST_RECOVER) begin
                cnt <= WAKE_CNT_RESET;
                phase_sys <= 1'b0;
            end else if (osc_done) begin
                cnt <= WAKE_CNT_RESET;
                phase_sys <= 1'b1;
            end else if (phase_sys || rc_tick_in) begin
                cnt <= cnt + 1'b1;
            end
            if (state == ST_RUN) begin
                watchdog_run_latched <= watchdog_enabled_in;
            end
        end
    end

    // Status flags; a new set wins over a clear in the same cycle.
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            wake_flag_out <= 1'b0;
            irq_pending <= 1'b0;
            watchdog_irq_out <= 1'b0;
            idle_exit_out <= 1'b0;
        end else begin
            if (state == ST_RECOVER && sys_done) begin
                wake_flag_out <= 1'b1;
            end else if (status_clear_in) begin
                wake_flag_out <= 1'b0;
            end
            if (state == ST_SLEEP && cause_in.watchdog_timeout && cause_in.watchdog_irq_mode) begin
                irq_pending <= irq_enabled_in;
            end else if (state == ST_RUN) begin
                irq_pending <= 1'b0;
            end
            watchdog_irq_out <= state == ST_RECOVER && sys_done && irq_pending;
            idle_exit_out <= state == ST_IDLE && idle_wake;
        end
    end

    // Registered power controls derived from the next state.
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            power_ctl_out <= '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0};
            recovery_reset_out <= 1'b0;
            state_out <= ST_RUN;
        end else begin
            power_ctl_out.xtal_en <= next_state != ST_SLEEP;
            power_ctl_out.sysclk_en <= next_state != ST_SLEEP;
            power_ctl_out.core_hold <= next_state != ST_RUN;
            power_ctl_out.periph_idle <= next_state == ST_SLEEP ||
                                         next_state == ST_RECOVER;
            power_ctl_out.rc_osc_en <= 1'b1;
            power_ctl_out.watchdog_run <= next_state == ST_RUN ? watchdog_enabled_in
                                          : watchdog_run_latched;
            recovery_reset_out <= next_state == ST_RECOVER;
            state_out <= next_state;
        end
    end

    // Helper for the checks: cycles spent so far in the system-clock phase of recovery.
    // A small counter keeps the phase-length check cheap instead of unrolling a repetition.
    logic [4:0] sys_len;
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            sys_len <= 5'h00;
        end else if (state == ST_RECOVER && phase_sys) begin
            sys_len <= sys_len + 5'h01;
        end else begin
            sys_len <= 5'h00;
        end
    end

    a_sleep_clock_off: assert property (@(posedge core_clk_in) disable iff (rst_in)
        state == ST_SLEEP |=> !power_ctl_out.sysclk_en || state != ST_SLEEP)
        else $error("system clock running in deep sleep");
    a_idle_clock_on: assert property (@(posedge core_clk_in) disable iff (rst_in)
        state == ST_IDLE && !idle_wake |=> power_ctl_out.xtal_en && power_ctl_out.core_hold)
        else $error("idle clocks wrong");
    a_idle_periph_run: assert property (@(posedge core_clk_in) disable iff (rst_in)
        state == ST_IDLE |-> !power_ctl_out.periph_idle)
        else $error("peripherals held in idle");
    a_sleep_exit_path: assert property (@(posedge core_clk_in) disable iff (rst_in)
        state == ST_SLEEP |=> state == ST_SLEEP || state == ST_RECOVER)
        else $error("deep sleep left without recovery");
    a_enter_sleep: assert property (@(posedge core_clk_in) disable iff (rst_in)
        state == ST_RUN && core_req_in.sleep_op |=> state == ST_SLEEP)
        else $error("sleep opcode ignored");
    a_enter_idle: assert property (@(posedge core_clk_in) disable iff (rst_in)
        state == ST_RUN && !core_req_in.sleep_op && core_req_in.idle_op |=> state == ST_IDLE)
        else $error("idle opcode ignored");
    a_idle_wake_fast: assert property (@(posedge core_clk_in) disable iff (rst_in)
        state == ST_IDLE && core_req_in.irq_taken |=> state == ST_RUN ##0 idle_exit_out)
        else $error("idle not ended by interrupt");
    // The phase ends after exactly the programmed number of system clocks.
    a_sys_phase_len: assert property (@(posedge core_clk_in) disable iff (rst_in)
        state == ST_RECOVER && phase_sys |=>
            state == ST_RECOVER || sys_len == 5'(WAKE_SYS_CYCLES))
        else $error("system clock phase length wrong");
    a_sys_phase_max: assert property (@(posedge core_clk_in) disable iff (rst_in)
        state == ST_RECOVER |-> sys_len < 5'(WAKE_SYS_CYCLES))
        else $error("system clock phase too long");
    a_recover_reset: assert property (@(posedge core_clk_in) disable iff (rst_in)
        state == ST_RECOVER |-> recovery_reset_out)
        else $error("reset not held during recovery");
    a_wake_flag_set: assert property (@(posedge core_clk_in) disable iff (rst_in)
        state == ST_RECOVER && sys_done |=> wake_flag_out)
        else $error("wakeup flag not set");
    a_pin_wake: assert property (@(posedge core_clk_in) disable iff (rst_in)
        state == ST_SLEEP && pin_wake |=> state == ST_RECOVER)
        else $error("pin edge did not wake");
    a_hold_core: assert property (@(posedge core_clk_in) disable iff (rst_in)
        state != ST_RUN |-> power_ctl_out.core_hold)
        else $error("core running in low power");
endmodule
`default_nettype wire

// ---- src/lpm_pkg.sv ----
package lpm_pkg;

    // Wakeup recovery hold: watchdog-oscillator cycles, then system-clock cycles.
    localparam int unsigned WAKE_OSC_CYCLES = 514;
    localparam int unsigned WAKE_SYS_CYCLES = 16;
    // Width of the recovery counter.
    localparam int unsigned WAKE_CNT_W = 10;
    // Counter value after reset.
    localparam logic [9:0] WAKE_CNT_RESET = 10'h000;
    // Default number of wakeup pins.
    localparam int unsigned WAKE_PINS_DEF = 8;

    // Power states, one-hot.
    typedef enum logic [3:0] {
        ST_RUN = 4'h1,
        ST_IDLE = 4'h2,
        ST_SLEEP = 4'h4,
        ST_RECOVER = 4'h8
    } power_state_t;

    // Requests from the processor core.
    typedef struct packed {
        logic sleep_op;
        logic idle_op;
        logic irq_taken;
    } core_req_t;

    // Reset and time-out causes.
    typedef struct packed {
        logic power_on_reset;
        logic low_supply_reset;
        logic ext_reset;
        logic watchdog_timeout;
        logic watchdog_irq_mode;
    } wake_cause_t;

    // Clock and activity controls toward the rest of the chip.
    typedef struct packed {
        logic xtal_en;
        logic sysclk_en;
        logic core_hold;
        logic periph_idle;
        logic rc_osc_en;
        logic watchdog_run;
    } power_ctl_t;

endpackage

// ---- verification/core_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// Stand-in for the processor core: each bench command becomes an opcode request one cycle later.
module core_model (
    // Clock and reset.
    input wire logic core_clk_in,
    input wire logic rst_in,
    // Command: 1 sleep, 2 idle, 3 interrupt taken; hold from the block.
    input wire logic [1:0] cmd_in,
    input wire logic hold_in,
    // Requests and fetch address.
    output var lpm_pkg::core_req_t req_out,
    output logic [15:0] program_counter_out
);
    import lpm_pkg::*;
    // Registered, so a request lasts as long as the command, one cycle behind it.
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            req_out <= '0;
            program_counter_out <= 16'h0000;
        end else begin
            req_out <= {cmd_in == 2'h1, cmd_in == 2'h2, cmd_in == 2'h3};
            // Fetch only advances while the block lets the core run.
            if (!hold_in) begin
                program_counter_out <= program_counter_out + 16'h0001;
            end
        end
    end
endmodule
`default_nettype wire

// ---- verification/tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb;
    import lpm_pkg::*;
    logic clk, rst, tick, wd_en, irq_en, clr, rec_rst, flag, wirq, iexit;
    logic [1:0] cmd;
    logic [7:0] pin, pin_en;
    logic [15:0] fetch_addr, p;
    wake_cause_t cause;
    core_req_t req;
    power_ctl_t ctl;
    power_state_t st;
    int err_count = 0, n_compared = 0, irq_seen = 0, exit_seen = 0, w;
    core_model core (.core_clk_in(clk), .rst_in(rst), .cmd_in(cmd), .hold_in(ctl.core_hold),
        .req_out(req), .program_counter_out(fetch_addr));
    low_power_mode_control dut (.core_clk_in(clk), .rst_in(rst), .rc_tick_in(tick),
        .core_req_in(req), .cause_in(cause), .watchdog_enabled_in(wd_en),
        .irq_enabled_in(irq_en), .status_clear_in(clr), .wake_pin_in(pin),
        .wake_pin_en_in(pin_en), .power_ctl_out(ctl), .recovery_reset_out(rec_rst),
        .wake_flag_out(flag), .watchdog_irq_out(wirq), .idle_exit_out(iexit), .state_out(st));
    // Clock at 20 MHz.
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // Pulses stand one cycle only, so they are counted at every edge.
    always @(posedge clk) begin
        if (wirq === 1'b1) irq_seen <= irq_seen + 1;
        if (iexit === 1'b1) exit_seen <= exit_seen + 1;
    end
    task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
        n_compared++;
        if (g !== e) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk);
    endtask
    // One command to the core model, one cycle long.
    task automatic op(input logic [1:0] c);
        @(posedge clk) cmd <= c;
        @(posedge clk) cmd <= 2'h0;
    endtask
    // Bounded wait for a state; judged on the falling edge where outputs are settled.
    task automatic wait_st(input power_state_t s, input int n);
        for (int i = 0; i < n && st !== s; i++) @(negedge clk);
        chk("state", 16'(s), 16'(st));
    endtask
    task automatic ticks(input int n);
        repeat (n) begin
            @(posedge clk) tick <= 1'b1;
            @(posedge clk) tick <= 1'b0;
        end
    endtask
    // Recovery must last all 514 ticks and then 16 clocks.
    task automatic recover;
        wait_st(ST_RECOVER, 8);
        chk("recovery reset", 16'h1, 16'(rec_rst));
        ticks(513);
        step(20);
        @(negedge clk);
        chk("still recovering", 16'(ST_RECOVER), 16'(st));
        ticks(1);
        step(15);
        @(negedge clk);
        chk("16 clocks", 16'(ST_RECOVER), 16'(st));
        @(negedge clk);
        chk("run after recovery", 16'(ST_RUN), 16'(st));
        chk("recovery reset off", 16'h0, 16'(rec_rst));
        chk("wake flag", 16'h1, 16'(flag));
    endtask
    task automatic t_idle;
        @(posedge clk) wd_en <= 1'b1;
        op(2'h2);
        wait_st(ST_IDLE, 8);
        chk("idle controls", 16'h3b, 16'(ctl));
        p = fetch_addr;
        step(5);
        chk("idle fetch address", p, fetch_addr);
        w = exit_seen;
        op(2'h3);
        wait_st(ST_RUN, 8);
        chk("idle exit pulse", 16'h1, 16'(iexit));
        // The pulse counter only takes the pulse at the following edge.
        @(negedge clk);
        chk("idle exit", 16'(w + 1), 16'(exit_seen));
        p = fetch_addr;
        step(2);
        @(negedge clk);
        chk("fetch resumes", 16'h2, fetch_addr - p);
    endtask
    // Every time-out and reset cause ends idle.
    task automatic t_causes;
        for (int i = 0; i < 5; i++) begin
            op(2'h2);
            wait_st(ST_IDLE, 8);
            @(posedge clk) cause <= (i == 4) ? 5'h03 : 5'(5'h10 >> i);
            @(posedge clk) cause <= 5'h00;
            wait_st(ST_RUN, 8);
        end
    endtask
    task automatic t_sleep_pin;
        op(2'h1);
        wait_st(ST_SLEEP, 8);
        chk("sleep controls", 16'h0f, 16'(ctl));
        p = fetch_addr;
        op(2'h3);
        @(posedge clk) pin <= 8'h01;
        step(10);
        chk("no wake", 16'(ST_SLEEP), 16'(st));
        chk("sleep fetch address", p, fetch_addr);
        w = irq_seen;
        @(posedge clk) pin <= 8'h81;
        recover();
        step(3);
        chk("no irq owed", 16'(w), 16'(irq_seen));
    endtask
    task automatic t_sleep_watchdog;
        wd_en <= 1'b0;
        irq_en <= 1'b1;
        @(posedge clk) clr <= 1'b1;
        @(posedge clk) clr <= 1'b0;
        step(2);
        chk("flag cleared", 16'h0, 16'(flag));
        op(2'h1);
        wait_st(ST_SLEEP, 8);
        chk("watchdog off", 16'h0e, 16'(ctl));
        w = irq_seen;
        @(posedge clk) cause <= 5'h03;
        @(posedge clk) cause <= 5'h00;
        recover();
        step(3);
        chk("irq after wake", 16'(w + 1), 16'(irq_seen));
    endtask
    task automatic report_and_stop;
        $display("errors %0d compares %0d", err_count, n_compared);
        if (err_count == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // Watchdog well past the few thousand cycles the tests need.
    initial begin
        #500000;
        err_count++;
        report_and_stop();
    end
    initial begin
        {rst, tick, wd_en, irq_en, clr, cmd, cause} = '0;
        rst = 1'b1;
        pin = 8'h00;
        pin_en = 8'h80;
        step(12);
        rst <= 1'b0;
        @(negedge clk);
        chk("reset controls", 16'h32, 16'(ctl));
        chk("reset state", 16'(ST_RUN), 16'(st));
        t_idle();
        t_causes();
        t_sleep_pin();
        t_sleep_watchdog();
        report_and_stop();
    end
endmodule
`default_nettype wire
